//--- verilog/hcs_pkg.sv
// Function
// - Link power status enables physical-layer talk
// - Power status low blocks physical-layer traffic; quadlet paths and acks do not check it
// - Resets clear power status; software only sets
// - Posted-write enable selects posted or pending ack
// - Link enable low: no received packets, no requests; transmit quadlets still pass
// - Physical-layer register access works with link off
// - Resets clear link enable; software never clears
// - Soft reset clears control bits and blocks both quadlet paths
// - Soft reset bit reads one during reset
// - Big-endian order sends bits 31:24 first
// - Header quadlets never byte-swapped
// - Swap bypass selects data quadlet byte order
// - Only listed transaction codes are swappable
// - Cycle time value never byte-swapped
// - Physical-layer packet data never byte-swapped
// - Set/clear addresses, ones act, both read back
package hcs_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] HCS_SET_OFFSET = 8'h50;
  localparam logic [7:0] HCS_CLEAR_OFFSET = 8'h54;

  // ==========================================================
  // Field positions
  localparam int HCS_BIT_SWAP_BYPASS = 30;
  localparam int HCS_BIT_LPS = 19;
  localparam int HCS_BIT_POSTED = 18;
  localparam int HCS_BIT_LINK_EN = 17;
  localparam int HCS_BIT_SELF_RESET = 16;
  localparam logic [31:0] HCS_RSVD_MASK = 32'hbff0ffff;

  // ==========================================================
  // Values after reset
  localparam logic HCS_LPS_RESET = 1'b0;
  localparam logic HCS_LINK_EN_RESET = 1'b0;
  localparam logic HCS_POSTED_RESET = 1'b0;
  localparam logic HCS_SWAP_BYPASS_RESET = 1'b0;

  // ==========================================================
  // Reset hold time in cycles
  localparam logic [4:0] HCS_RESET_HOLD_CYCLES = 5'h10;

  // ==========================================================
  // Transaction codes
  localparam logic [3:0] HCS_TC_QUAD_WRITE = 4'h0;
  localparam logic [3:0] HCS_TC_BLOCK_WRITE = 4'h1;
  localparam logic [3:0] HCS_TC_QUAD_RESP = 4'h6;
  localparam logic [3:0] HCS_TC_BLOCK_RESP = 4'h7;
  localparam logic [3:0] HCS_TC_LOCK_REQ = 4'h9;
  localparam logic [3:0] HCS_TC_STREAM = 4'ha;
  localparam logic [3:0] HCS_TC_LOCK_RESP = 4'hb;
  localparam logic [3:0] HCS_TC_PHY_PACKET = 4'he;

  typedef enum logic [1:0] {
    HCS_ST_RUN = 2'b01,
    HCS_ST_RESET = 2'b10
  } hcs_state_t;

  // ==========================================================
  // Data quadlets subject to byte order control
  function automatic logic hcs_swappable(input logic [3:0] tcode);
    logic hit;
    hit = 1'b0;
    unique case (tcode)
      HCS_TC_QUAD_WRITE, HCS_TC_BLOCK_WRITE, HCS_TC_QUAD_RESP,
      HCS_TC_BLOCK_RESP, HCS_TC_LOCK_REQ, HCS_TC_STREAM,
      HCS_TC_LOCK_RESP: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic [31:0] hcs_byte_reverse(input logic [31:0] q);
    return {q[7:0], q[15:8], q[23:16], q[31:24]};
  endfunction

endpackage

//--- verilog/hcs_quadlet_swap.sv
module hcs_quadlet_swap (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [31:0] quadIn,
  input wire logic [3:0] tcode,
  input wire logic isHeader,
  input wire logic isCycleTime,
  input wire logic inValid,
  input wire logic swapBypass,
  output logic [31:0] quadOut,
  output logic outValid
);

  // ==========================================================
  // Byte order selection
  logic doSwap;

  assign doSwap = !isHeader && !isCycleTime && !swapBypass
                  && hcs_pkg::hcs_swappable(tcode);

  // Output lane: bits 31:24 leave the link first
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      quadOut <= 32'h00000000;
    end else if (inValid) begin
      quadOut <= doSwap ? hcs_pkg::hcs_byte_reverse(quadIn) : quadIn;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      outValid <= 1'b0;
    end else begin
      outValid <= inValid;
    end
  end

  // ==========================================================
  // Checks
  property p_header_kept;
    @(posedge sys_clk) disable iff (rst)
    inValid && (isHeader || isCycleTime) |=> quadOut == $past(quadIn);
  endproperty
  a_header_kept: assert property (p_header_kept)
    else $error("header or cycle time quadlet was swapped");

  property p_data_swapped;
    @(posedge sys_clk) disable iff (rst)
    inValid && !isHeader && !isCycleTime && !swapBypass
      && hcs_pkg::hcs_swappable(tcode)
      |=> quadOut == hcs_pkg::hcs_byte_reverse($past(quadIn));
  endproperty
  a_data_swapped: assert property (p_data_swapped)
    else $error("swappable data quadlet not reversed");

  property p_phy_data_kept;
    @(posedge sys_clk) disable iff (rst)
    inValid && tcode == hcs_pkg::HCS_TC_PHY_PACKET |=> quadOut == $past(quadIn);
  endproperty
  a_phy_data_kept: assert property (p_phy_data_kept)
    else $error("phy packet data was swapped");

endmodule

//--- verilog/hcs_host_link_control.sv
module hcs_host_link_control (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  output logic regRdValid,
  input wire logic phyCtrlReq,
  output logic phyRequestLine,
  output logic phyCommEnable,
  input wire logic busReqIn,
  output logic busRequest,
  input wire logic rxPacketValid,
  output logic rxPacketAccept,
  input wire logic physWriteReq,
  output logic ackPostedOut,
  output logic ackPendingOut,
  output logic linkActive,
  output logic resetInProgress,
  input wire logic [31:0] txQuadIn,
  input wire logic [3:0] txTcode,
  input wire logic txIsHeader,
  input wire logic txIsCycleTime,
  input wire logic txValid,
  output logic [31:0] txQuadOut,
  output logic txQuadValid,
  input wire logic [31:0] rxQuadIn,
  input wire logic [3:0] rxTcode,
  input wire logic rxIsHeader,
  input wire logic rxIsCycleTime,
  input wire logic rxValid,
  output logic [31:0] rxQuadOut,
  output logic rxQuadValid
);

  // ==========================================================
  // Control state
  logic linkPowerStatus;
  logic postedWriteEn;
  logic linkActiveEn;
  logic swapBypass;
  hcs_pkg::hcs_state_t state;
  hcs_pkg::hcs_state_t next_state;
  logic [4:0] holdCount;
  logic setHit;
  logic clearHit;
  logic softStart;
  logic resetBusy;
  logic mappedAddr;
  logic [31:0] readValue;

  localparam int RST_BOUND = 18;

  assign setHit = regWrite && (regAddr == hcs_pkg::HCS_SET_OFFSET);
  assign clearHit = regWrite && (regAddr == hcs_pkg::HCS_CLEAR_OFFSET);
  assign mappedAddr = (regAddr == hcs_pkg::HCS_SET_OFFSET)
                      || (regAddr == hcs_pkg::HCS_CLEAR_OFFSET);
  assign resetBusy = (state == hcs_pkg::HCS_ST_RESET);
  assign softStart = !resetBusy && setHit && regWdata[hcs_pkg::HCS_BIT_SELF_RESET];

  // ==========================================================
  // Reset sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      hcs_pkg::HCS_ST_RUN: begin
        if (softStart) begin
          next_state = hcs_pkg::HCS_ST_RESET;
        end
      end
      hcs_pkg::HCS_ST_RESET: begin
        if (holdCount == hcs_pkg::HCS_RESET_HOLD_CYCLES - 5'h01) begin
          next_state = hcs_pkg::HCS_ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= hcs_pkg::HCS_ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || !resetBusy) begin
      holdCount <= 5'h00;
    end else begin
      holdCount <= holdCount + 5'h01;
    end
  end

  // Busy flag seen by software and by the queues
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      resetInProgress <= 1'b1;
    end else begin
      resetInProgress <= (next_state == hcs_pkg::HCS_ST_RESET);
    end
  end

  // ==========================================================
  // Link power status, set only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      linkPowerStatus <= hcs_pkg::HCS_LPS_RESET;
    end else if (resetBusy || softStart) begin
      linkPowerStatus <= hcs_pkg::HCS_LPS_RESET;
    end else if (setHit && regWdata[hcs_pkg::HCS_BIT_LPS]) begin
      linkPowerStatus <= 1'b1;
    end
  end

  // ==========================================================
  // Link enable, set only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      linkActiveEn <= hcs_pkg::HCS_LINK_EN_RESET;
    end else if (resetBusy || softStart) begin
      linkActiveEn <= hcs_pkg::HCS_LINK_EN_RESET;
    end else if (setHit && regWdata[hcs_pkg::HCS_BIT_LINK_EN]) begin
      linkActiveEn <= 1'b1;
    end
  end

  // ==========================================================
  // Posted write enable, set and clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      postedWriteEn <= hcs_pkg::HCS_POSTED_RESET;
    end else if (resetBusy || softStart) begin
      postedWriteEn <= hcs_pkg::HCS_POSTED_RESET;
    end else if (setHit && regWdata[hcs_pkg::HCS_BIT_POSTED]) begin
      postedWriteEn <= 1'b1;
    end else if (clearHit && regWdata[hcs_pkg::HCS_BIT_POSTED]) begin
      postedWriteEn <= 1'b0;
    end
  end

  // ==========================================================
  // Data swap bypass, set and clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      swapBypass <= hcs_pkg::HCS_SWAP_BYPASS_RESET;
    end else if (resetBusy || softStart) begin
      swapBypass <= hcs_pkg::HCS_SWAP_BYPASS_RESET;
    end else if (setHit && regWdata[hcs_pkg::HCS_BIT_SWAP_BYPASS]) begin
      swapBypass <= 1'b1;
    end else if (clearHit && regWdata[hcs_pkg::HCS_BIT_SWAP_BYPASS]) begin
      swapBypass <= 1'b0;
    end
  end

  // ==========================================================
  // Read path
  always_comb begin
    readValue = 32'h00000000;
    readValue[hcs_pkg::HCS_BIT_SWAP_BYPASS] = swapBypass;
    readValue[hcs_pkg::HCS_BIT_LPS] = linkPowerStatus;
    readValue[hcs_pkg::HCS_BIT_POSTED] = postedWriteEn;
    readValue[hcs_pkg::HCS_BIT_LINK_EN] = linkActiveEn;
    readValue[hcs_pkg::HCS_BIT_SELF_RESET] = resetBusy;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      regRdata <= 32'h00000000;
    end else if (regRead) begin
      regRdata <= mappedAddr ? readValue : 32'h00000000;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRead;
    end
  end

  // ==========================================================
  // Physical-layer side
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phyCommEnable <= 1'b0;
    end else begin
      phyCommEnable <= linkPowerStatus;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phyRequestLine <= 1'b0;
    end else begin
      phyRequestLine <= phyCtrlReq && linkPowerStatus;
    end
  end

  // ==========================================================
  // Bus side, gated by link enable
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      linkActive <= 1'b0;
    end else begin
      linkActive <= linkActiveEn;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busRequest <= 1'b0;
    end else begin
      busRequest <= busReqIn && linkActiveEn && linkPowerStatus;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rxPacketAccept <= 1'b0;
    end else begin
      rxPacketAccept <= rxPacketValid && linkActiveEn && linkPowerStatus;
    end
  end

  // Physical write acknowledge choice
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ackPostedOut <= 1'b0;
      ackPendingOut <= 1'b0;
    end else begin
      ackPostedOut <= physWriteReq && linkActiveEn && postedWriteEn;
      ackPendingOut <= physWriteReq && linkActiveEn && !postedWriteEn;
    end
  end

  // ==========================================================
  // Quadlet byte order, both directions
  hcs_quadlet_swap u_tx_swap (
    .sys_clk(sys_clk),
    .rst(rst),
    .quadIn(txQuadIn),
    .tcode(txTcode),
    .isHeader(txIsHeader),
    .isCycleTime(txIsCycleTime),
    .inValid(txValid && !resetBusy),
    .swapBypass(swapBypass),
    .quadOut(txQuadOut),
    .outValid(txQuadValid)
  );

  hcs_quadlet_swap u_rx_swap (
    .sys_clk(sys_clk),
    .rst(rst),
    .quadIn(rxQuadIn),
    .tcode(rxTcode),
    .isHeader(rxIsHeader),
    .isCycleTime(rxIsCycleTime),
    .inValid(rxValid && linkActiveEn && !resetBusy),
    .swapBypass(swapBypass),
    .quadOut(rxQuadOut),
    .outValid(rxQuadValid)
  );

  // ==========================================================
  // Checks
  property p_phy_req_needs_lps;
    @(posedge sys_clk) disable iff (rst)
    phyRequestLine |-> $past(linkPowerStatus);
  endproperty
  a_phy_req_needs_lps: assert property (p_phy_req_needs_lps)
    else $error("phy request without link power status");

  property p_phy_ctrl_link_off;
    @(posedge sys_clk) disable iff (rst)
    phyCtrlReq && linkPowerStatus && !linkActiveEn |=> phyRequestLine;
  endproperty
  a_phy_ctrl_link_off: assert property (p_phy_ctrl_link_off)
    else $error("phy register access dropped while link off");

  property p_lps_falls_on_reset;
    @(posedge sys_clk) disable iff (rst)
    $fell(linkPowerStatus) |-> resetBusy;
  endproperty
  a_lps_falls_on_reset: assert property (p_lps_falls_on_reset)
    else $error("link power status cleared outside reset");

  property p_link_clear_in_reset;
    @(posedge sys_clk) disable iff (rst)
    resetBusy |-> !linkActiveEn && !linkPowerStatus && !postedWriteEn;
  endproperty
  a_link_clear_in_reset: assert property (p_link_clear_in_reset)
    else $error("control bits set during reset");

  property p_no_bus_req_off;
    @(posedge sys_clk) disable iff (rst)
    busRequest || rxPacketAccept |-> $past(linkActiveEn);
  endproperty
  a_no_bus_req_off: assert property (p_no_bus_req_off)
    else $error("bus activity while link disabled");

  property p_ack_choice;
    @(posedge sys_clk) disable iff (rst)
    physWriteReq && linkActiveEn |=> (ackPostedOut == $past(postedWriteEn))
      && (ackPendingOut == !$past(postedWriteEn));
  endproperty
  a_ack_choice: assert property (p_ack_choice)
    else $error("wrong acknowledge for physical write");

  property p_reset_ends;
    @(posedge sys_clk) disable iff (rst)
    $rose(resetBusy) |-> resetBusy[*8] ##[1:RST_BOUND] !resetBusy;
  endproperty
  a_reset_ends: assert property (p_reset_ends)
    else $error("soft reset length wrong");

  property p_readback;
    @(posedge sys_clk) disable iff (rst)
    regRead && mappedAddr |=> regRdata[hcs_pkg::HCS_BIT_LPS] == $past(linkPowerStatus)
      && regRdata[hcs_pkg::HCS_BIT_SELF_RESET] == $past(resetBusy);
  endproperty
  a_readback: assert property (p_readback)
    else $error("register readback mismatch");

  property p_reserved_zero;
    @(posedge sys_clk) disable iff (rst)
    regRdValid |-> (regRdata & hcs_pkg::HCS_RSVD_MASK) == 32'h00000000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read nonzero");

  property p_clear_posted;
    @(posedge sys_clk) disable iff (rst)
    clearHit && regWdata[hcs_pkg::HCS_BIT_POSTED] |=> !postedWriteEn;
  endproperty
  a_clear_posted: assert property (p_clear_posted)
    else $error("clear address did not clear posted write enable");

endmodule

//--- sim/hcs_phy_model.sv
module hcs_phy_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic phyRequestLine,
  input wire logic sendReq,
  input wire logic [31:0] sendQuad,
  input wire logic [3:0] sendTcode,
  input wire logic sendHdr,
  input wire logic sendCyc,
  output logic [31:0] rxQuadIn,
  output logic [3:0] rxTcode,
  output logic rxIsHeader,
  output logic rxIsCycleTime,
  output logic rxValid,
  output logic [7:0] reqCount
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================
  // Quadlet source toward the link
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rxValid <= 1'b0;
      rxQuadIn <= 32'h00000000;
      rxTcode <= 4'h0;
      rxIsHeader <= 1'b0;
      rxIsCycleTime <= 1'b0;
    end else if (sendReq) begin
      rxValid <= 1'b1;
      rxQuadIn <= sendQuad;
      rxTcode <= sendTcode;
      rxIsHeader <= sendHdr;
      rxIsCycleTime <= sendCyc;
    end else begin
      rxValid <= 1'b0;
      rxQuadIn <= ~rxQuadIn;
      rxTcode <= ~rxTcode;
      rxIsHeader <= ~rxIsHeader;
      rxIsCycleTime <= ~rxIsCycleTime;
    end
  end

  // ==========================================
  // Request line activity counter
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reqCount <= 8'h00;
    end else if (phyRequestLine) begin
      reqCount <= reqCount + 8'h01;
    end
  end
endmodule

//--- sim/hcs_host_link_control_tb_top.sv
module hcs_host_link_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk, rst, regWrite, regRead, regRdValid, phyCtrlReq, phyRequestLine;
  logic phyCommEnable, busReqIn, busRequest, rxPacketValid, rxPacketAccept;
  logic physWriteReq, ackPostedOut, ackPendingOut, linkActive, resetInProgress;
  logic txIsHeader, txIsCycleTime, txValid, txQuadValid, rxIsHeader, rxIsCycleTime;
  logic rxValid, rxQuadValid, sendReq, sendHdr, sendCyc;
  logic [7:0] regAddr, reqCount;
  logic [31:0] regWdata, regRdata, txQuadIn, txQuadOut, rxQuadIn, rxQuadOut, sendQuad;
  logic [3:0] txTcode, rxTcode, sendTcode;
  int errors = 0;
  int totalChecks = 0;
  int cycles = 0;
  localparam logic [7:0] SA = hcs_pkg::HCS_SET_OFFSET;
  localparam logic [7:0] CA = hcs_pkg::HCS_CLEAR_OFFSET;

  hcs_host_link_control uut (
    .sys_clk, .rst, .regAddr, .regWrite, .regRead, .regWdata, .regRdata, .regRdValid,
    .phyCtrlReq, .phyRequestLine, .phyCommEnable, .busReqIn, .busRequest,
    .rxPacketValid, .rxPacketAccept, .physWriteReq, .ackPostedOut, .ackPendingOut,
    .linkActive, .resetInProgress, .txQuadIn, .txTcode, .txIsHeader, .txIsCycleTime,
    .txValid, .txQuadOut, .txQuadValid, .rxQuadIn, .rxTcode, .rxIsHeader,
    .rxIsCycleTime, .rxValid, .rxQuadOut, .rxQuadValid
  );

  hcs_phy_model phy (
    .sys_clk, .rst, .phyRequestLine, .sendReq, .sendQuad, .sendTcode, .sendHdr,
    .sendCyc, .rxQuadIn, .rxTcode, .rxIsHeader, .rxIsCycleTime, .rxValid, .reqCount
  );

  // ==========================================
  // Clock and timeout
  always #10 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      summarize();
    end
  end

  // ==========================================
  // Shared tasks
  task automatic summarize();
    $display("checks %0d errors %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    @(negedge sys_clk);
    cmp("rdvalid", 32'h1, {31'h0, regRdValid});
    cmp("rdata", exp, regRdata);
  endtask

  task automatic gates(input logic [4:0] exp);
    @(posedge sys_clk);
    {phyCtrlReq, busReqIn, rxPacketValid, physWriteReq} <= 4'hf;
    @(posedge sys_clk);
    {phyCtrlReq, busReqIn, rxPacketValid, physWriteReq} <= 4'h0;
    @(negedge sys_clk);
    cmp("gates", {27'h0, exp}, {27'h0, phyRequestLine, busRequest, rxPacketAccept,
        ackPostedOut, ackPendingOut});
  endtask

  function automatic logic [31:0] expq(input logic [31:0] q, input logic [3:0] tc,
      input logic hdr, input logic cyc, input logic byp);
    if (!hdr && !cyc && !byp && (tc < 4'h2 || tc == 4'h6 || tc == 4'h7 ||
        (tc > 4'h8 && tc < 4'hc))) begin
      return {q[7:0], q[15:8], q[23:16], q[31:24]};
    end
    return q;
  endfunction

  task automatic quad(input logic [3:0] tc, input logic hdr, input logic cyc,
      input logic byp);
    logic [31:0] q;
    q = 32'h11223344 ^ {8{tc}};
    @(posedge sys_clk);
    {txQuadIn, txTcode, txIsHeader, txIsCycleTime, txValid} <= {q, tc, hdr, cyc, 1'b1};
    {sendQuad, sendTcode, sendHdr, sendCyc, sendReq} <= {q, tc, hdr, cyc, 1'b1};
    @(posedge sys_clk);
    txValid <= 1'b0;
    sendReq <= 1'b0;
    @(negedge sys_clk);
    cmp("txvalid", 32'h1, {31'h0, txQuadValid});
    cmp("txquad", expq(q, tc, hdr, cyc, byp), txQuadOut);
    @(negedge sys_clk);
    cmp("rxvalid", 32'h1, {31'h0, rxQuadValid});
    cmp("rxquad", expq(q, tc, hdr, cyc, byp), rxQuadOut);
  endtask

  task automatic sweep(input logic byp);
    for (int k = 0; k < 18; k++) begin
      quad(k[3:0], k == 16, k == 17, byp);
    end
  endtask

  task automatic idle_wait();
    int n;
    n = 0;
    while (resetInProgress !== 1'b0 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    cmp("busy", 32'h0, {31'h0, resetInProgress});
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset();
    rd(SA, 32'h00010000);
    rd(8'h58, 32'h0);
    idle_wait();
    rd(CA, 32'h0);
    gates(5'b00000);
  endtask

  task automatic t_regs();
    wr(SA, 32'h00080000);
    rd(SA, 32'h00080000);
    gates(5'b10000);
    cmp("power", 32'h1, {31'h0, phyCommEnable});
    wr(SA, 32'hfff4ffff);
    rd(CA, 32'h400c0000);
    wr(CA, 32'hbff0ffff);
    rd(SA, 32'h400c0000);
    wr(CA, 32'h40040000);
    rd(SA, 32'h00080000);
    wr(SA, 32'h00020000);
    rd(SA, 32'h000a0000);
    cmp("link", 32'h1, {31'h0, linkActive});
    gates(5'b11101);
    sweep(1'b0);
  endtask

  task automatic t_soft();
    wr(SA, 32'h00090000);
    @(negedge sys_clk);
    cmp("busy", 32'h1, {31'h0, resetInProgress});
    @(negedge sys_clk);
    cmp("link", 32'h0, {31'h0, linkActive});
    rd(SA, 32'h00010000);
    idle_wait();
    rd(SA, 32'h0);
    @(posedge sys_clk);
    sendReq <= 1'b1;
    @(posedge sys_clk);
    sendReq <= 1'b0;
    repeat (2) begin
      @(negedge sys_clk);
      cmp("rxgate", 32'h0, {31'h0, rxQuadValid});
    end
  endtask

  task automatic t_posted();
    wr(SA, 32'h00080000);
    wr(SA, 32'h40040000);
    wr(SA, 32'h00020000);
    rd(SA, 32'h400e0000);
    gates(5'b11110);
    @(negedge sys_clk);
    cmp("reqcount", 32'h3, {24'h0, reqCount});
    sweep(1'b1);
  endtask

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    {regWrite, regRead, phyCtrlReq, busReqIn, rxPacketValid, physWriteReq} = 6'h0;
    {txIsHeader, txIsCycleTime, txValid, sendReq, sendHdr, sendCyc} = 6'h0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    txQuadIn = 32'h0;
    sendQuad = 32'h0;
    txTcode = 4'h0;
    sendTcode = 4'h0;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    cmp("busy", 32'h1, {31'h0, resetInProgress});
    @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_soft();
    t_posted();
    summarize();
  end
endmodule
